// File: iccap_consts.svh
// register offsets, field positions and reset values of the data path
`ifndef ICCAP_CONSTS_SVH
`define ICCAP_CONSTS_SVH
`define ICCAP_A_CNT 8'h00
`define ICCAP_A_DRR 8'h04
`define ICCAP_A_SAR 8'h08
`define ICCAP_A_DXR 8'h0c
`define ICCAP_A_MDR 8'h10
`define ICCAP_A_STR 8'h14
`define ICCAP_A_IMR 8'h18
`define ICCAP_M_STP 11
`define ICCAP_M_MST 10
`define ICCAP_M_TRX 9
`define ICCAP_M_XA 8
`define ICCAP_M_RM 7
`define ICCAP_M_FDF 3
`define ICCAP_M_BC 2:0
`define ICCAP_MDR_WMASK 16'hefff
`define ICCAP_S_RX 0
`define ICCAP_S_TX 1
`define ICCAP_S_STOP 2
`define ICCAP_S_CNT 3
`define ICCAP_SAR_RST 10'h3ff
`define ICCAP_FULL_CNT 17'h10000
`define ICCAP_WORD_MAX 4'h8
`define ICCAP_WIDE_PFX 5'h1e
`endif

// File: iccap_pkg.sv
// types shared by the data path modules
package iccap_pkg;
  typedef enum logic [1:0] {
    ICCAP_IDLE = 2'h0,
    ICCAP_ADDR = 2'h1,
    ICCAP_DATA = 2'h3,
    ICCAP_ACK = 2'h2
  } iccap_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iccap_bus_t;

  typedef struct packed {
    logic [2:0] stg;
    logic lvl;
  } iccap_sync_st_t;

  typedef struct packed {
    logic [16:0] value;
  } iccap_cnt_st_t;

  typedef struct packed {
    iccap_phase_t phase;
    logic [15:0] count;
    logic [15:0] mode;
    logic [9:0] taddr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [3:0] bits;
    logic wide2;
    logic addr_ack;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic sda_o;
    logic sda_oe;
    logic stop_gen;
    logic scl_q;
    logic sda_q;
  } iccap_st_t;
endpackage : iccap_pkg

// File: iccap_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module iccap_sync import iccap_pkg::*; #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pin side
  input wire logic din,
  // clock side
  output logic lvl
);
  iccap_sync_st_t r;
  iccap_sync_st_t n;

  always_comb begin
    n = r;
    n.stg = {r.stg[1:0], din};
    // only stages two and three are compared
    if (r.stg[1] == r.stg[2]) begin
      n.lvl = r.stg[2];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{stg: {3{INIT}}, lvl: INIT};
    end else begin
      r <= n;
    end
  end

  assign lvl = r.lvl;
endmodule : iccap_sync

// File: iccap_cnt.sv
// internal word down-counter
`timescale 1ns/1ps
`include "iccap_consts.svh"
module iccap_cnt import iccap_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic dec,
  // state
  output logic [16:0] value
);
  iccap_cnt_st_t r;
  iccap_cnt_st_t n;

  always_comb begin
    n = r;
    if (load) begin
      n.value = (load_val == 16'h0) ? `ICCAP_FULL_CNT : {1'b0, load_val};
    end else if (dec && r.value != 17'h0) begin
      n.value = r.value - 17'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{value: 17'h0};
    end else begin
      r <= n;
    end
  end

  assign value = r.value;
endmodule : iccap_cnt

// File: iccap_top.sv
// data path of the two-wire controller: count, address, holding and shift registers
//
// Contract
// - programmed count is used only as master-transmitter with repeat off.
// - written count goes to a down-counter, decremented per word; register unchanged.
// - with stop requested, a stop is issued when the down-counter reaches zero.
// - written zero loads 65536; other values load themselves.
// - in repeat mode the count is ignored and never ends a transfer.
// - short received words are right-aligned; upper bits undefined.
// - bits per word come from the mode register field for both directions.
// - received bits fill a hidden shift register, then copy to receive data.
// - shift registers are never visible to software; only holding registers.
// - reading receive data clears the receive-ready flag.
// - reserved upper bits read zero and ignore writes, except mode bits 15-13, which are stored and read back.
// - as master with free format off, transfers begin with the stored target address.
// - nonzero address selects one target; in 7-bit mode zero is sent as general call, in wide mode as a 10-bit address.
// - 7-bit mode sends bits 6-0; wide mode sends all ten bits.
// - transmit data is copied into a hidden shift register and shifted out.
// - stop request clears itself once the stop appears on the bus.
`timescale 1ns/1ps
`include "iccap_consts.svh"
module iccap_top import iccap_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire iccap_bus_t bus_req,
  output logic [31:0] rdata,
  output logic irq,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  // to the rest of the controller
  output logic stop_gen
);
  iccap_st_t r;
  iccap_st_t n;
  logic scl_l;
  logic sda_l;
  logic [16:0] cnt_val;
  logic cnt_load;
  logic cnt_dec;
  logic [3:0] nbits;
  logic xmit;
  logic count_mode;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic word_done;
  logic [7:0] tx_load;

  // ***************************************
  // pin synchronisers and counter
  // ***************************************
  iccap_sync #(.INIT(1'b1)) u_scl_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(scl_in),
    .lvl(scl_l)
  );

  iccap_sync #(.INIT(1'b1)) u_sda_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(sda_in),
    .lvl(sda_l)
  );

  iccap_cnt u_cnt (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(cnt_load),
    .load_val(r.count),
    .dec(cnt_dec),
    .value(cnt_val)
  );

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    n = r;
    cnt_load = 1'b0;
    cnt_dec = 1'b0;
    word_done = 1'b0;
    n.stop_gen = 1'b0;
    n.scl_q = scl_l;
    n.sda_q = sda_l;
    nbits = (r.mode[`ICCAP_M_BC] == 3'h0) ? `ICCAP_WORD_MAX : {1'b0, r.mode[`ICCAP_M_BC]};
    tx_load = r.txd << (`ICCAP_WORD_MAX - nbits);
    xmit = (r.phase == ICCAP_ADDR) || r.mode[`ICCAP_M_TRX];
    count_mode = r.mode[`ICCAP_M_MST] && r.mode[`ICCAP_M_TRX] && !r.mode[`ICCAP_M_RM];
    scl_rise = scl_l && !r.scl_q;
    scl_fall = !scl_l && r.scl_q;
    start_seen = r.scl_q && scl_l && r.sda_q && !sda_l;
    stop_seen = r.scl_q && scl_l && !r.sda_q && sda_l;

    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `ICCAP_A_CNT: n.count = bus_req.wdata[15:0];
        `ICCAP_A_SAR: n.taddr = bus_req.wdata[9:0];
        `ICCAP_A_DXR: n.txd = bus_req.wdata[7:0];
        `ICCAP_A_MDR: n.mode = bus_req.wdata[15:0] & `ICCAP_MDR_WMASK;
        `ICCAP_A_STR: n.status = r.status & ~bus_req.wdata[3:0];
        `ICCAP_A_IMR: n.mask = bus_req.wdata[3:0];
        default: ;
      endcase
    end

    // register reads, shift registers have no address
    n.rdata = 32'h0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `ICCAP_A_CNT: n.rdata = {16'h0, r.count};
        `ICCAP_A_DRR: begin
          n.rdata = {24'h0, r.rxd};
          n.status[`ICCAP_S_RX] = 1'b0;
        end
        `ICCAP_A_SAR: n.rdata = {22'h0, r.taddr};
        `ICCAP_A_DXR: n.rdata = {24'h0, r.txd};
        `ICCAP_A_MDR: n.rdata = {16'h0, r.mode};
        `ICCAP_A_STR: n.rdata = {28'h0, r.status};
        `ICCAP_A_IMR: n.rdata = {28'h0, r.mask};
        default: n.rdata = 32'h0;
      endcase
    end

    // ***************************************
    // serial side
    // ***************************************
    if (stop_seen) begin
      n.phase = ICCAP_IDLE;
      n.sda_oe = 1'b0;
      n.status[`ICCAP_S_STOP] = 1'b1;
      n.mode[`ICCAP_M_STP] = 1'b0;
    end else if (start_seen) begin
      n.bits = 4'h0;
      n.wide2 = 1'b0;
      n.sda_oe = 1'b0;
      if (r.mode[`ICCAP_M_MST] && !r.mode[`ICCAP_M_FDF]) begin
        n.phase = ICCAP_ADDR;
        // in 7-bit mode a zero address goes out unchanged as the general call; wide mode sends it behind the prefix
        if (r.mode[`ICCAP_M_XA]) begin
          n.txsh = {`ICCAP_WIDE_PFX, r.taddr[9:8], !r.mode[`ICCAP_M_TRX]};
        end else begin
          n.txsh = {r.taddr[6:0], !r.mode[`ICCAP_M_TRX]};
        end
      end else begin
        n.phase = ICCAP_DATA;
        n.txsh = tx_load;
        n.status[`ICCAP_S_TX] = 1'b1;
      end
      cnt_load = count_mode;
    end else begin
      case (r.phase)
        ICCAP_ADDR, ICCAP_DATA: begin
          if (scl_fall) begin
            // address bytes are always full width, data words follow the mode field
            if ((r.phase == ICCAP_DATA && r.bits == nbits) ||
                (r.phase == ICCAP_ADDR && r.bits == `ICCAP_WORD_MAX)) begin
              n.phase = ICCAP_ACK;
              n.addr_ack = (r.phase == ICCAP_ADDR);
              n.sda_oe = !xmit;
            end else begin
              n.sda_oe = xmit && !r.txsh[7];
              n.txsh = {r.txsh[6:0], 1'b0};
            end
          end
          if (scl_rise) begin
            n.rxsh = {r.rxsh[6:0], sda_l};
            n.bits = r.bits + 4'h1;
          end
        end
        ICCAP_ACK: begin
          if (scl_rise) begin
            n.bits = 4'h0;
            if (r.addr_ack && r.mode[`ICCAP_M_XA] && !r.wide2) begin
              n.phase = ICCAP_ADDR;
              n.wide2 = 1'b1;
              n.txsh = r.taddr[7:0];
            end else begin
              n.phase = ICCAP_DATA;
              n.txsh = tx_load;
              n.status[`ICCAP_S_TX] = 1'b1;
              if (!r.addr_ack) begin
                word_done = 1'b1;
                if (!r.mode[`ICCAP_M_TRX]) begin
                  n.rxd = r.rxsh;
                  n.status[`ICCAP_S_RX] = 1'b1;
                end
                cnt_dec = count_mode;
                if (count_mode && cnt_val == 17'h1) begin
                  n.status[`ICCAP_S_CNT] = 1'b1;
                  n.stop_gen = r.mode[`ICCAP_M_STP];
                end
              end
            end
          end
        end
        default: n.phase = ICCAP_IDLE;
      endcase
    end

    n.sda_o = 1'b0;
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{phase: ICCAP_IDLE, count: 16'h0, mode: 16'h0, taddr: `ICCAP_SAR_RST,
             txd: 8'h0, rxd: 8'h0, txsh: 8'h0, rxsh: 8'h0, bits: 4'h0,
             wide2: 1'b0, addr_ack: 1'b0, status: 4'h0, mask: 4'h0,
             rdata: 32'h0, irq: 1'b0, sda_o: 1'b0, sda_oe: 1'b0,
             stop_gen: 1'b0, scl_q: 1'b1, sda_q: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign irq = r.irq;
  assign sda_o = r.sda_o;
  assign sda_oe = r.sda_oe;
  assign stop_gen = r.stop_gen;

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_count_read_back: assert property (
    bus_req.rd && bus_req.addr == `ICCAP_A_CNT && !bus_req.wr
    |=> rdata == {16'h0, $past(r.count)})
    else $error("count read back wrong");

  a_rx_flag_clear: assert property (
    bus_req.rd && bus_req.addr == `ICCAP_A_DRR && !word_done |=> !r.status[`ICCAP_S_RX])
    else $error("receive flag not cleared by read");

  a_count_reload: assert property (
    cnt_load |=> cnt_val == (($past(r.count) == 16'h0) ? `ICCAP_FULL_CNT : {1'b0, $past(r.count)}))
    else $error("down-counter reload wrong");

  a_count_step: assert property (
    word_done && count_mode && cnt_val != 17'h0 && !cnt_load |=> cnt_val == $past(cnt_val) - 17'h1)
    else $error("down-counter did not step");

  a_repeat_quiet: assert property (
    r.mode[`ICCAP_M_RM] && $stable(r.mode) |=> !stop_gen)
    else $error("stop issued in repeat mode");

  a_stop_on_zero: assert property (
    word_done && count_mode && cnt_val == 17'h1 && r.mode[`ICCAP_M_STP]
    |=> stop_gen ##1 cnt_val == 17'h0)
    else $error("stop not issued at count end");

  a_stop_self_clear: assert property (
    stop_seen && !(bus_req.wr && bus_req.addr == `ICCAP_A_MDR) |=> !r.mode[`ICCAP_M_STP])
    else $error("stop request not cleared");

  a_rx_copy: assert property (
    word_done && !r.mode[`ICCAP_M_TRX] |=> r.rxd == $past(r.rxsh) && r.status[`ICCAP_S_RX])
    else $error("receive word not copied");

  a_addr_short: assert property (
    start_seen && r.mode[`ICCAP_M_MST] && !r.mode[`ICCAP_M_FDF] && !r.mode[`ICCAP_M_XA]
    |=> r.txsh == {$past(r.taddr[6:0]), !$past(r.mode[`ICCAP_M_TRX])})
    else $error("7-bit address load wrong");

  a_msb_first: assert property (
    scl_fall && !stop_seen && !start_seen && r.phase == ICCAP_ADDR && r.bits != `ICCAP_WORD_MAX
    |=> sda_oe == !$past(r.txsh[7]))
    else $error("address bit order wrong");

  c_tx_word: cover property (word_done && r.mode[`ICCAP_M_TRX]);
  c_rx_word: cover property (word_done && !r.mode[`ICCAP_M_TRX]);
  c_stop_gen: cover property (stop_gen);
  c_wide_addr: cover property (r.wide2 && r.phase == ICCAP_ACK);
endmodule : iccap_top

// File: iccap_peer.sv
// far-side bus peer: clocks the link, frames it, drives data and acknowledge
`timescale 1ns/1ps
module iccap_peer (
  // clock
  input wire logic clock,
  // serial bus
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // ****************
  // link sequencing
  // ****************
  // link clock stands high between frames; sda has a pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task start_c();
    wt(4);
    pull <= 1'b1;
    wt(4);
    scl <= 1'b0;
  endtask : start_c

  // data changes mid-low, sampled at end of high
  // long low phase: the block answers five clocks after a fall
  task bit_c(input logic b, output logic seen);
    wt(3);
    pull <= !b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    seen = sda;
    scl <= 1'b0;
  endtask : bit_c

  task stop_c();
    wt(3);
    pull <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(4);
    pull <= 1'b0;
    wt(4);
  endtask : stop_c
endmodule : iccap_peer

// File: i2c_data_count_address_path_test.sv
// self-checking bench of the data path: registers, serial frames, interrupt
`timescale 1ns/1ps
`include "iccap_consts.svh"
module i2c_data_count_address_path_test import iccap_pkg::*; ;
  logic clock;
  logic sys_rst;
  iccap_bus_t bus_req;
  logic [31:0] rdata;
  logic irq, sda_oe, stop_gen, scl, pull, sda;
  int bad_count = 0;
  int n_tests = 0;
  int n_stop = 0;

  // open-drain wire with pull-up
  assign sda = !(sda_oe | pull);

  iccap_top dut (.clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
    .irq(irq), .scl_in(scl), .sda_in(sda), .sda_o(), .sda_oe(sda_oe),
    .stop_gen(stop_gen));
  iccap_peer peer (.clock(clock), .sda(sda), .scl(scl), .pull(pull));

  initial clock = 1'b0;
  always #50 clock = !clock;
  always @(posedge clock) if (stop_gen === 1'b1) n_stop <= n_stop + 1;

  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rchk

  task irq_is(input logic e);
    repeat (3) @(posedge clock);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task tdone(input int k);
    $display("test %0d done", k);
  endtask : tdone

  // n data bits msb first, then the acknowledge bit
  task word(input int n, input logic [7:0] d, input logic a, output logic [8:0] g);
    logic b;
    g = 9'h0;
    for (int i = n - 1; i >= 0; i--) begin
      peer.bit_c(d[i], b);
      g = {g[7:0], b};
    end
    peer.bit_c(a, b);
    g = {g[7:0], b};
  endtask : word

  task tx_frame(input logic [15:0] m, input int na, input logic [15:0] ea, input int nw,
      input int ns);
    logic [8:0] g;
    int s0;
    s0 = n_stop;
    wr(`ICCAP_A_MDR, {16'h0, m});
    peer.start_c();
    for (int i = 0; i < na; i++) begin
      word(8, 8'hff, 1'b0, g);
      chk(32'(g), {23'h0, ea[15:8], 1'b0});
      ea = ea << 8;
    end
    for (int i = 0; i < nw; i++) begin
      word(8, 8'hff, 1'b0, g);
      chk(32'(g), {23'h0, 8'ha5, 1'b0});
    end
    peer.stop_c();
    chk(32'(n_stop - s0), 32'(ns));
  endtask : tx_frame

  task finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ****************
  // tests
  // ****************
  initial begin
    logic [31:0] v;
    logic [8:0] g;
    sys_rst = 1'b1;
    bus_req = '0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(`ICCAP_A_CNT, 32'h0);
    rchk(`ICCAP_A_DRR, 32'h0);
    rchk(`ICCAP_A_SAR, 32'h3ff);
    rchk(`ICCAP_A_DXR, 32'h0);
    wr(`ICCAP_A_CNT, 32'hffffffff);
    rchk(`ICCAP_A_CNT, 32'hffff);
    wr(`ICCAP_A_DXR, 32'hffffffa5);
    rchk(`ICCAP_A_DXR, 32'ha5);
    wr(`ICCAP_A_SAR, 32'hfffffbd5);
    rchk(`ICCAP_A_SAR, 32'h3d5);
    rchk(8'h1c, 32'h0);
    tdone(1);
    // upper address bits ignored in 7-bit mode
    wr(`ICCAP_A_CNT, 32'h2);
    tx_frame(16'h0e00, 1, 16'haa00, 1, 0);
    tx_frame(16'h0e00, 1, 16'haa00, 2, 1);
    rchk(`ICCAP_A_MDR, 32'h0600);
    rchk(`ICCAP_A_CNT, 32'h2);
    rd(`ICCAP_A_STR, v);
    chk({30'h0, v[3:2]}, 32'h3);
    tdone(2);
    wr(`ICCAP_A_CNT, 32'h0);
    tx_frame(16'h0e00, 1, 16'haa00, 2, 0);
    wr(`ICCAP_A_CNT, 32'h1);
    tx_frame(16'h0e80, 1, 16'haa00, 2, 0);
    wr(`ICCAP_A_SAR, 32'h2b4);
    tx_frame(16'h0f00, 2, 16'hf4b4, 1, 1);
    wr(`ICCAP_A_SAR, 32'h0);
    tx_frame(16'h0e00, 1, 16'h0000, 1, 1);
    tx_frame(16'h0608, 0, 16'h0000, 1, 0);
    tdone(3);
    // 3-bit receive words, interrupt raise, mask and clear
    wr(`ICCAP_A_STR, 32'hf);
    wr(`ICCAP_A_IMR, 32'h1);
    wr(`ICCAP_A_MDR, 32'h0403);
    peer.start_c();
    word(8, 8'hff, 1'b0, g);
    chk(32'(g), 32'h2);
    word(3, 8'h05, 1'b1, g);
    chk({28'h0, g[3:0]}, 32'ha);
    irq_is(1'b1);
    wr(`ICCAP_A_IMR, 32'h0);
    irq_is(1'b0);
    peer.stop_c();
    wr(`ICCAP_A_IMR, 32'h1);
    irq_is(1'b1);
    rd(`ICCAP_A_DRR, v);
    chk({29'h0, v[2:0]}, 32'h5);
    chk({8'h0, v[31:8]}, 32'h0);
    irq_is(1'b0);
    rd(`ICCAP_A_STR, v);
    chk({31'h0, v[0]}, 32'h0);
    wr(`ICCAP_A_STR, 32'hf);
    rchk(`ICCAP_A_STR, 32'h0);
    tdone(4);
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    finish_test();
  end
endmodule : i2c_data_count_address_path_test
